/* hdl/rid_defines.svh */
// Operation
// [RL1] add acc and file; c, nibble carry, z
// [RL2] and acc with file; z only
// [RL3] zero file register, set z
// [RL4] zero accumulator, set z
// [RL5] invert file register; z only
// [RL6] decrement file register; z only
// [RL7] decrement, skip next when zero
// [RL8] increment, skip next when zero
// [RL9] rotate left/right through carry; c only
// [RL10] or / xor acc with file; z
// [RL11] clear or set one file bit
// [RL12] test bit, skip if low
// [RL13] test bit, skip if high
// [RL14] call: push pc+1, page-latched target
// [RL15] jump: page-latched target, no push
// [RL16] add literal to acc; c, nibble carry, z
// [RL17] and/or/xor literal into acc; z
// [RL18] watchdog clear, both status bits set
// [RL19] standby entry updates both status bits
// [RL20] return with literal, pop stack
// [RL21] port read-modify-write uses pin levels
// [RL22] timer write clears its prescaler
// [RL23] interrupt return pops, sets irq enable
// [RL24] remaining byte and literal ops decoded
`ifndef RID_DEFINES_SVH
`define RID_DEFINES_SVH
`define RID_PC_RST      13'h0000
`define RID_ACC_RST     8'h00
`define RID_ADDR_TIMER  7'h01
`define RID_ADDR_PORT_A 7'h05
`define RID_ADDR_PORT_B 7'h06
`define RID_ADDR_PORT_C 7'h07
`define RID_F_MSB       6
`define RID_D_BIT       7
`define RID_B_LSB       7
`define RID_B_MSB       9
`define RID_K11_MSB     10
`define RID_PAGE_LSB    3
`define RID_PAGE_MSB    4
`endif

/* hdl/rid_pkg.sv */
package rid_pkg;
    typedef enum logic [5:0] {
        o_nop, o_add_f, o_and_f, o_zero_f, o_zero_w, o_inv_f, o_dec_f, o_dec_skz, o_inc_f,
        o_inc_skz, o_or_f, o_mov_f, o_mov_wf, o_rol_f, o_ror_f, o_sub_f, o_swap_f, o_xor_f,
        o_bit_clr, o_bit_set, o_tst_low, o_tst_high, o_add_l, o_and_l, o_call, o_wdt_clr,
        o_jump, o_or_l, o_mov_l, o_irq_ret, o_ret_l, o_ret, o_standby, o_sub_l, o_xor_l
    } rid_op_t;

    // file register write port
    typedef struct packed {
        logic       en;
        logic [6:0] addr;
        logic [7:0] data;
    } rid_wr_t;

    // status flags; expiry and sleep bits are active low as in the status word
    typedef struct packed {
        logic carry;
        logic nibble_carry_flag;
        logic zero;
        logic watchdog_expiry_flag;
        logic sleep_entered_flag;
    } rid_flags_t;

    // alu answer with per-flag update enables
    typedef struct packed {
        logic [7:0] val;
        logic       c;
        logic       nc;
        logic       z;
        logic       c_en;
        logic       nc_en;
        logic       z_en;
        logic       skip;
    } rid_alu_t;
endpackage

/* hdl/rid_alu.sv */
`timescale 1ns/1ns
`default_nettype none
module rid_alu import rid_pkg::*; (
    input  wire rid_op_t    op,
    input  wire logic [7:0] acc,
    input  wire logic [7:0] fval,
    input  wire logic [7:0] lit,
    input  wire logic [2:0] bsel,
    input  wire logic       c_in,
    output rid_alu_t        res
);
    // {carry, nibble carry, sum}
    function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
        logic [4:0] lo;
        logic [8:0] full;
        lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        return {full[8], lo[4], full[7:0]};
    endfunction

    logic [9:0] s;

    // operation select and flag enables
    always_comb begin
        res   = '0;
        res.c = c_in;
        s     = '0;
        case (op)
            o_add_f:    begin s = add8(acc, fval, 1'b0); res.val = s[7:0]; res.c = s[9]; res.nc = s[8]; end // RL1
            o_sub_f:    begin s = add8(fval, ~acc, 1'b1); res.val = s[7:0]; res.c = s[9]; res.nc = s[8]; end
            o_add_l:    begin s = add8(acc, lit, 1'b0); res.val = s[7:0]; res.c = s[9]; res.nc = s[8]; end // RL16
            o_sub_l:    begin s = add8(lit, ~acc, 1'b1); res.val = s[7:0]; res.c = s[9]; res.nc = s[8]; end
            o_and_f:    res.val = acc & fval; // RL2
            o_or_f:     res.val = acc | fval; // RL10
            o_xor_f:    res.val = acc ^ fval; // RL10
            o_and_l:    res.val = acc & lit; // RL17
            o_or_l:     res.val = acc | lit; // RL17
            o_xor_l:    res.val = acc ^ lit; // RL17
            o_inv_f:    res.val = ~fval; // RL5
            o_dec_f,
            o_dec_skz:  res.val = fval - 8'h01; // RL6 RL7
            o_inc_f,
            o_inc_skz:  res.val = fval + 8'h01; // RL8
            o_mov_f:    res.val = fval;
            o_mov_wf:   res.val = acc;
            o_mov_l,
            o_ret_l:    res.val = lit; // RL20
            o_swap_f:   res.val = {fval[3:0], fval[7:4]};
            o_rol_f:    begin res.val = {fval[6:0], c_in}; res.c = fval[7]; end // RL9
            o_ror_f:    begin res.val = {c_in, fval[7:1]}; res.c = fval[0]; end // RL9
            o_bit_clr:  res.val = fval & ~(8'h01 << bsel); // RL11
            o_bit_set:  res.val = fval | (8'h01 << bsel); // RL11
            o_tst_low:  res.skip = ~fval[bsel]; // RL12
            o_tst_high: res.skip = fval[bsel]; // RL13
            default:    res.val = 8'h00; // RL3 RL4
        endcase
        res.z = (res.val == 8'h00);
        if (op == o_dec_skz || op == o_inc_skz) begin
            res.skip = res.z; // RL7 RL8
        end
        res.c_en  = (op inside {o_add_f, o_sub_f, o_add_l, o_sub_l, o_rol_f, o_ror_f});
        res.nc_en = (op inside {o_add_f, o_sub_f, o_add_l, o_sub_l});
        res.z_en  = (op inside {o_add_f, o_sub_f, o_add_l, o_sub_l, o_and_f, o_or_f, o_xor_f,
                                o_and_l, o_or_l, o_xor_l, o_inv_f, o_dec_f, o_inc_f, o_mov_f,
                                o_zero_f, o_zero_w});
    end
endmodule
`default_nettype wire

/* hdl/rid_core.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rid_defines.svh"
module rid_core import rid_pkg::*; #(
    parameter int STACK_DEPTH = 8
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [13:0] instr_word,
    output logic      [12:0] prog_addr,
    output logic      [6:0]  file_raddr,
    input  wire logic [7:0]  file_rdata,
    input  wire logic [7:0]  pin_rdata,
    input  wire logic [4:0]  page_latch,
    input  wire logic        presc_on_timer,
    input  wire logic        gie_clear,
    output rid_wr_t          file_wr,
    output logic      [7:0]  acc,
    output rid_flags_t       flags,
    output logic             global_irq_enable,
    output logic             wdt_clr,
    output logic             presc_clr,
    output logic             sleep_req
);
    localparam int SPW = $clog2(STACK_DEPTH);

    rid_op_t          op;
    rid_op_t          op_x;
    rid_alu_t         alu;
    rid_wr_t          wr_q;
    rid_flags_t       flg_q;
    logic [12:0]      pc_q;
    logic [12:0]      pc_inc;
    logic [12:0]      pc_d;
    logic [12:0]      target;
    logic [12:0]      stk_q [STACK_DEPTH];
    logic [SPW-1:0]   sp_q;
    logic [7:0]       acc_q;
    logic [7:0]       fval;
    logic             flush_q;
    logic             flush_adv_q;
    logic             gie_q;
    logic             wdt_clr_q;
    logic             presc_clr_q;
    logic             sleep_q;
    logic             is_branch;
    logic             is_pop;
    logic             wr_file;
    logic             wr_acc;

    // instruction word to operation
    function automatic rid_op_t decode(input logic [13:0] w);
        casez (w)
            14'b00_0111_????_????: return o_add_f; // RL1
            14'b00_0101_????_????: return o_and_f; // RL2
            14'b00_0001_1???_????: return o_zero_f; // RL3
            14'b00_0001_0???_????: return o_zero_w; // RL4
            14'b00_1001_????_????: return o_inv_f; // RL5
            14'b00_0011_????_????: return o_dec_f; // RL6
            14'b00_1011_????_????: return o_dec_skz; // RL7
            14'b00_1010_????_????: return o_inc_f; // RL24
            14'b00_1111_????_????: return o_inc_skz; // RL8
            14'b00_0100_????_????: return o_or_f; // RL10
            14'b00_1000_????_????: return o_mov_f; // RL24
            14'b00_0000_1???_????: return o_mov_wf; // RL24
            14'b00_0000_0110_0100: return o_wdt_clr; // RL18
            14'b00_0000_0110_0011: return o_standby; // RL19
            14'b00_0000_0000_1001: return o_irq_ret; // RL23
            14'b00_0000_0000_1000: return o_ret; // RL24
            14'b00_1101_????_????: return o_rol_f; // RL9
            14'b00_1100_????_????: return o_ror_f; // RL9
            14'b00_0010_????_????: return o_sub_f; // RL24
            14'b00_1110_????_????: return o_swap_f; // RL24
            14'b00_0110_????_????: return o_xor_f; // RL10
            14'b01_00??_????_????: return o_bit_clr; // RL11
            14'b01_01??_????_????: return o_bit_set; // RL11
            14'b01_10??_????_????: return o_tst_low; // RL12
            14'b01_11??_????_????: return o_tst_high; // RL13
            14'b11_111?_????_????: return o_add_l; // RL16
            14'b11_1001_????_????: return o_and_l; // RL17
            14'b11_1000_????_????: return o_or_l; // RL17
            14'b11_1010_????_????: return o_xor_l; // RL17
            14'b11_00??_????_????: return o_mov_l; // RL24
            14'b11_01??_????_????: return o_ret_l; // RL20
            14'b11_110?_????_????: return o_sub_l; // RL24
            14'b10_0???_????_????: return o_call; // RL14
            14'b10_1???_????_????: return o_jump; // RL15
            default:               return o_nop;
        endcase
    endfunction

    // decode; a flushed slot runs as a no-operation
    assign op   = decode(instr_word);
    assign op_x = flush_q ? o_nop : op;

    // operand fetch: pending write bypass, then port pins
    assign file_raddr = instr_word[`RID_F_MSB:0];
    always_comb begin
        fval = file_rdata;
        if (wr_q.en && wr_q.addr == file_raddr) begin
            fval = wr_q.data;
        end
        if (file_raddr inside {`RID_ADDR_PORT_A, `RID_ADDR_PORT_B, `RID_ADDR_PORT_C}) begin
            fval = pin_rdata; // RL21
        end
    end

    rid_alu u_alu (
        .op   (op_x),
        .acc  (acc_q),
        .fval (fval),
        .lit  (instr_word[7:0]),
        .bsel (instr_word[`RID_B_MSB:`RID_B_LSB]),
        .c_in (flg_q.carry),
        .res  (alu)
    );

    // destination select from the d bit
    always_comb begin
        wr_file = 1'b0;
        wr_acc  = 1'b0;
        case (op_x)
            o_add_f, o_and_f, o_inv_f, o_dec_f, o_dec_skz, o_inc_f, o_inc_skz, o_or_f,
            o_mov_f, o_rol_f, o_ror_f, o_sub_f, o_swap_f, o_xor_f: begin
                wr_file = instr_word[`RID_D_BIT];
                wr_acc  = ~instr_word[`RID_D_BIT];
            end
            o_zero_f, o_mov_wf, o_bit_clr, o_bit_set: wr_file = 1'b1; // RL3 RL11
            o_zero_w, o_add_l, o_and_l, o_or_l, o_xor_l, o_mov_l, o_ret_l, o_sub_l: wr_acc = 1'b1; // RL4 RL20
            default: begin
                wr_file = 1'b0;
                wr_acc  = 1'b0;
            end
        endcase
    end

    // next program counter
    assign pc_inc    = pc_q + 13'h0001;
    assign target    = {page_latch[`RID_PAGE_MSB:`RID_PAGE_LSB], instr_word[`RID_K11_MSB:0]};
    assign is_pop    = (op_x inside {o_ret, o_ret_l, o_irq_ret});
    assign is_branch = (op_x inside {o_call, o_jump}) || is_pop;
    always_comb begin
        if (flush_q) begin
            pc_d = flush_adv_q ? pc_inc : pc_q;
        end else if (op_x == o_call || op_x == o_jump) begin
            pc_d = target; // RL14 RL15
        end else if (is_pop) begin
            pc_d = stk_q[sp_q - SPW'(1)]; // RL20 RL23
        end else begin
            pc_d = pc_inc;
        end
    end

    // program counter and dummy-cycle tracking
    always_ff @(posedge mclk) begin
        if (rst) begin
            pc_q        <= `RID_PC_RST;
            flush_q     <= 1'b0;
            flush_adv_q <= 1'b0;
        end else if (ce) begin
            pc_q        <= pc_d;
            flush_q     <= is_branch || alu.skip; // RL7 RL8 RL12 RL13
            flush_adv_q <= alu.skip;
        end
    end

    // return stack, circular
    always_ff @(posedge mclk) begin
        if (rst) begin
            sp_q <= '0;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stk_q[i] <= '0;
            end
        end else if (ce) begin
            if (op_x == o_call) begin
                stk_q[sp_q] <= pc_inc; // RL14
                sp_q        <= sp_q + SPW'(1);
            end else if (is_pop) begin
                sp_q <= sp_q - SPW'(1); // RL20 RL23
            end
        end
    end

    // accumulator
    always_ff @(posedge mclk) begin
        if (rst) begin
            acc_q <= `RID_ACC_RST;
        end else if (ce && wr_acc) begin
            acc_q <= alu.val;
        end
    end

    // file register write, one cycle after execute
    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_q <= '0;
        end else if (ce) begin
            wr_q.en   <= wr_file;
            wr_q.addr <= file_raddr;
            wr_q.data <= alu.val;
        end
    end

    // arithmetic flags and the two power status bits
    always_ff @(posedge mclk) begin
        if (rst) begin
            flg_q <= '{carry: 1'b0, nibble_carry_flag: 1'b0, zero: 1'b0,
                       watchdog_expiry_flag: 1'b1, sleep_entered_flag: 1'b1};
        end else if (ce) begin
            if (alu.c_en) flg_q.carry <= alu.c; // RL1 RL9 RL16
            if (alu.nc_en) flg_q.nibble_carry_flag <= alu.nc; // RL1 RL16
            if (alu.z_en) flg_q.zero <= alu.z; // RL2 RL5 RL6 RL10 RL17
            if (op_x == o_wdt_clr) begin
                flg_q.watchdog_expiry_flag <= 1'b1; // RL18
                flg_q.sleep_entered_flag   <= 1'b1;
            end else if (op_x == o_standby) begin
                flg_q.watchdog_expiry_flag <= 1'b1; // RL19
                flg_q.sleep_entered_flag   <= 1'b0;
            end
        end
    end

    // side-effect pulses and global irq enable; set wins over clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            gie_q       <= 1'b0;
            wdt_clr_q   <= 1'b0;
            presc_clr_q <= 1'b0;
            sleep_q     <= 1'b0;
        end else if (ce) begin
            if (op_x == o_irq_ret) begin
                gie_q <= 1'b1; // RL23
            end else if (gie_clear) begin
                gie_q <= 1'b0;
            end
            wdt_clr_q   <= (op_x == o_wdt_clr) || (op_x == o_standby); // RL18 RL19
            presc_clr_q <= wr_file && file_raddr == `RID_ADDR_TIMER && presc_on_timer; // RL22
            sleep_q     <= (op_x == o_standby);
        end
    end

    assign prog_addr         = pc_q;
    assign file_wr           = wr_q;
    assign acc               = acc_q;
    assign flags             = flg_q;
    assign global_irq_enable = gie_q;
    assign wdt_clr           = wdt_clr_q;
    assign presc_clr         = presc_clr_q;
    assign sleep_req         = sleep_q;

    // checks
    sequence s_call_taken;
        ce && op_x == o_call;
    endsequence
    sequence s_dummy_slot;
        flush_q && !is_branch && !alu.z_en && !wr_file && !wr_acc;
    endsequence

    chk_skip_zero_dec: assert property (@(posedge mclk) disable iff (rst) // RL7
        ce && op_x == o_dec_skz && alu.val == 8'h00 |=> s_dummy_slot)
        else $error("decrement to zero did not discard next slot");
    chk_call_push_pc: assert property (@(posedge mclk) disable iff (rst) // RL14
        s_call_taken |=> stk_q[sp_q - SPW'(1)] == $past(pc_inc) && pc_q == $past(target))
        else $error("call did not push return address or load target");
    chk_jump_no_push: assert property (@(posedge mclk) disable iff (rst) // RL15
        ce && op_x == o_jump |=> sp_q == $past(sp_q) && pc_q == $past(target) ##0 s_dummy_slot)
        else $error("jump moved stack or missed target");
    chk_tst_low_skip: assert property (@(posedge mclk) disable iff (rst) // RL12
        ce && op_x == o_tst_low && !fval[instr_word[`RID_B_MSB:`RID_B_LSB]] |=> pc_q == $past(pc_inc)
        ##0 s_dummy_slot)
        else $error("low bit test did not discard next slot");
    chk_zero_acc_op: assert property (@(posedge mclk) disable iff (rst) // RL4
        ce && op_x == o_zero_w |=> acc == 8'h00 && flags.zero)
        else $error("accumulator clear failed");
    chk_wdt_clear_bits: assert property (@(posedge mclk) disable iff (rst) // RL18
        ce && op_x == o_wdt_clr |=> wdt_clr && flags.watchdog_expiry_flag && flags.sleep_entered_flag)
        else $error("watchdog clear effects missing");
    chk_standby_bits: assert property (@(posedge mclk) disable iff (rst) // RL19
        ce && op_x == o_standby |=> sleep_req && !flags.sleep_entered_flag)
        else $error("standby did not update status bits");
    chk_timer_presc_clr: assert property (@(posedge mclk) disable iff (rst) // RL22
        ce && wr_file && file_raddr == `RID_ADDR_TIMER && presc_on_timer |=> presc_clr
        ##0 file_wr.en && file_wr.addr == `RID_ADDR_TIMER)
        else $error("timer write left prescaler running");
    chk_irq_ret_gie: assert property (@(posedge mclk) disable iff (rst) // RL23
        ce && op_x == o_irq_ret |=> global_irq_enable && pc_q == $past(pc_d))
        else $error("interrupt return did not enable irqs");
    chk_ret_lit_acc: assert property (@(posedge mclk) disable iff (rst) // RL20
        ce && op_x == o_ret_l |=> acc == $past(instr_word[7:0]) && flush_q)
        else $error("return with literal wrong");
    chk_port_pin_src: assert property (@(posedge mclk) disable iff (rst) // RL21
        file_raddr == `RID_ADDR_PORT_A |-> fval == pin_rdata)
        else $error("port operand not taken from pins");
endmodule
`default_nettype wire

/* dv/rid_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
// program memory and data file facing the core
module rid_mem_model import rid_pkg::*; (
    input  wire logic [12:0] prog_addr,
    output logic      [13:0] instr_word,
    input  wire logic        mclk,
    input  wire logic [6:0]  file_raddr,
    output logic      [7:0]  file_rdata,
    input  wire logic [7:0]  pin_level,
    output logic      [7:0]  pin_rdata,
    input  wire rid_wr_t     file_wr
);
    logic [13:0] rom [0:8191];
    logic [7:0]  ram [0:127];
    // unused words are no-ops, data starts cleared
    initial begin
        for (int i = 0; i < 8192; i++) begin
            rom[i] = 14'h0000;
        end
        for (int i = 0; i < 128; i++) begin
            ram[i] = 8'h00;
        end
    end
    // same-cycle reads
    assign instr_word = rom[prog_addr];
    assign file_rdata = ram[file_raddr];
    assign pin_rdata  = pin_level;
    // write presented by the core commits at the next edge
    always @(posedge mclk) begin
        if (file_wr.en === 1'b1) begin
            ram[file_wr.addr] <= file_wr.data;
        end
    end
endmodule
`default_nettype wire

/* dv/test_risc_instruction_decoder.sv */
`timescale 1ns/1ns
`default_nettype none
`define RID_CHECK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module test_risc_instruction_decoder import rid_pkg::*; ();
    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] data;
        logic [2:0] cnz;
    } rid_note_t;
    logic        mclk;
    logic        rst;
    logic        ce;
    logic        hold_ce;
    logic [4:0]  page_latch;
    logic        presc_on_timer;
    logic        gie_clear;
    logic [7:0]  pin_level;
    logic [13:0] instr_word;
    logic [12:0] prog_addr;
    logic [6:0]  file_raddr;
    logic [7:0]  file_rdata;
    logic [7:0]  pin_rdata;
    rid_wr_t     file_wr;
    logic [7:0]  acc;
    rid_flags_t  flags;
    logic        global_irq_enable;
    logic        wdt_clr;
    logic        presc_clr;
    logic        sleep_req;
    rid_note_t   notes [$];
    rid_note_t   n;
    int          fail_count;
    int          compares;
    int          cycles;
    int          n_wdt;
    int          n_presc;
    int          n_sleep;
    logic [12:0] wp;
    logic [7:0]  a, b, k, p, w4, v9, v10, v11, v12, sa, wl, si;
    logic [8:0]  s;
    logic        nc1, ca, nca;
    logic [2:0]  fb, fl, fs;

    rid_core #(.STACK_DEPTH(8)) dut (.mclk(mclk), .rst(rst), .ce(ce), .instr_word(instr_word),
        .prog_addr(prog_addr), .file_raddr(file_raddr), .file_rdata(file_rdata), .pin_rdata(pin_rdata),
        .page_latch(page_latch), .presc_on_timer(presc_on_timer), .gie_clear(gie_clear), .file_wr(file_wr),
        .acc(acc), .flags(flags), .global_irq_enable(global_irq_enable), .wdt_clr(wdt_clr),
        .presc_clr(presc_clr), .sleep_req(sleep_req));
    rid_mem_model pm (.prog_addr(prog_addr), .instr_word(instr_word), .mclk(mclk), .file_raddr(file_raddr),
        .file_rdata(file_rdata), .pin_level(pin_level), .pin_rdata(pin_rdata), .file_wr(file_wr));

    task automatic give_verdict();
        if (fail_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    function automatic logic [13:0] fop(input logic [5:0] op, input logic d, input logic [6:0] f);
        return {op, d, f};
    endfunction
    function automatic logic [13:0] lop(input logic [5:0] op, input logic [7:0] kv);
        return {op, kv};
    endfunction
    // place a word in program memory
    task automatic put(input logic [13:0] w);
        pm.rom[wp] = w;
        wp = wp + 13'h0001;
    endtask
    // place a word and note the file write it must cause
    task automatic ow(input logic [13:0] w, input logic [7:0] d, input logic [2:0] cnz);
        put(w);
        notes.push_back({w[6:0], d, cnz});
    endtask

    // clock, 40 ns period
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // random clock enable stalls between executions
    always @(posedge mclk) begin
        #1;
        ce = (rst || hold_ce) ? 1'b1 : 1'($urandom_range(3) != 0);
        // prescaler owned by the timer only while running from the odd pages (prog_addr bit 11 set)
        presc_on_timer = prog_addr[11];
    end
    // hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            $display("[FAIL] %0t timeout", $time);
            give_verdict();
        end
    end
    // scoreboard: each file write takes the oldest note
    always @(posedge mclk) begin
        if (!rst && ce === 1'b1 && file_wr.en === 1'b1) begin
            if (notes.size() == 0) begin
                fail_count++;
                $display("[FAIL] %0t unexpected write to %h", $time, file_wr.addr);
            end else begin
                n = notes.pop_front();
                `RID_CHECK({file_wr.addr, file_wr.data}, {n.addr, n.data})
                `RID_CHECK({flags.carry, flags.nibble_carry_flag, flags.zero}, n.cnz)
            end
        end
    end
    // pulse counts, one per executing cycle
    always @(posedge mclk) begin
        if (!rst && ce === 1'b1) begin
            n_wdt += int'(wdt_clr === 1'b1);
            n_presc += int'(presc_clr === 1'b1);
            n_sleep += int'(sleep_req === 1'b1);
        end
    end

    // program load, expectations, final checks
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        hold_ce = 1'b0;
        presc_on_timer = 1'b1;
        gie_clear = 1'b0;
        void'($urandom(32505));
        a = 8'($urandom);
        b = 8'($urandom);
        k = 8'($urandom);
        p = 8'($urandom) | 8'h01;
        pin_level = p;
        page_latch = {2'b01, 3'($urandom)};
        @(posedge mclk);
        wp = 13'h0000;
        s = {1'b0, a} + {1'b0, b};
        nc1 = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f;
        w4 = b & s[7:0];
        v9 = w4 | 8'hfe;
        v10 = v9 ^ w4;
        v11 = {v10[6:0], s[8]};
        v12 = {v10[7], v11[7:1]};
        fb = {v11[0], nc1, v10 == 8'h00};
        sa = 8'hff + k;
        ca = k != 8'h00;
        nca = k[3:0] != 4'h0;
        wl = ((k & b) | 8'h81) ^ a;
        fl = {ca, nca, wl == 8'h00};
        si = {s[3:0], s[7:4]} + 8'h01;
        fs = {b >= a, b[3:0] >= a[3:0], b == a};
        put(lop(6'h30, a));
        ow(fop(6'h00, 1'b1, 7'h20), a, 3'b000);
        put(lop(6'h30, b));
        ow(fop(6'h07, 1'b1, 7'h20), s[7:0], {s[8], nc1, s[7:0] == 8'h00});
        put(fop(6'h05, 1'b0, 7'h20));
        ow(fop(6'h00, 1'b1, 7'h21), w4, {s[8], nc1, w4 == 8'h00});
        ow(fop(6'h01, 1'b1, 7'h21), 8'h00, {s[8], nc1, 1'b1});
        ow(fop(6'h09, 1'b1, 7'h21), 8'hff, {s[8], nc1, 1'b0});
        ow(fop(6'h03, 1'b1, 7'h21), 8'hfe, {s[8], nc1, 1'b0});
        ow(fop(6'h04, 1'b1, 7'h21), v9, {s[8], nc1, 1'b0});
        ow(fop(6'h06, 1'b1, 7'h21), v10, {s[8], nc1, v10 == 8'h00});
        ow(fop(6'h0d, 1'b1, 7'h21), v11, {v10[7], nc1, v10 == 8'h00});
        ow(fop(6'h0c, 1'b1, 7'h21), v12, fb);
        ow({4'b0101, 3'd5, 7'h22}, 8'h20, fb);
        ow({4'b0100, 3'd0, 7'h21}, v12 & 8'hfe, fb);
        put({4'b0110, 3'd5, 7'h22});
        ow(fop(6'h00, 1'b1, 7'h23), w4, fb);
        put({4'b0110, 3'd4, 7'h22});
        put(fop(6'h00, 1'b1, 7'h24));
        put({4'b0111, 3'd5, 7'h22});
        put(fop(6'h00, 1'b1, 7'h24));
        put(lop(6'h30, 8'h01));
        ow(fop(6'h00, 1'b1, 7'h25), 8'h01, fb);
        ow(fop(6'h0b, 1'b1, 7'h25), 8'h00, fb);
        put(fop(6'h00, 1'b1, 7'h24));
        put(lop(6'h30, 8'hff));
        ow(fop(6'h00, 1'b1, 7'h26), 8'hff, fb);
        ow(fop(6'h0f, 1'b1, 7'h26), 8'h00, fb);
        put(fop(6'h00, 1'b1, 7'h24));
        put(lop(6'h3e, k));
        ow(fop(6'h00, 1'b1, 7'h2b), sa, {ca, nca, sa == 8'h00});
        put(fop(6'h01, 1'b0, 7'h00));
        ow(fop(6'h00, 1'b1, 7'h2c), 8'h00, {ca, nca, 1'b1});
        put(lop(6'h30, k));
        put(lop(6'h39, b));
        put(lop(6'h38, 8'h81));
        put(lop(6'h3a, a));
        ow(fop(6'h00, 1'b1, 7'h27), wl, fl);
        put(lop(6'h30, a));
        ow(fop(6'h00, 1'b1, 7'h01), a, fl);
        ow(fop(6'h0e, 1'b1, 7'h20), {s[3:0], s[7:4]}, fl);
        ow(fop(6'h0a, 1'b1, 7'h20), si, {fl[2:1], si == 8'h00});
        ow(fop(6'h02, 1'b1, 7'h20), si - a, {si >= a, si[3:0] >= a[3:0], si == a});
        put(lop(6'h3c, b));
        put(14'h2101);
        ow(fop(6'h00, 1'b1, 7'h2d), b - a, fs);
        put(14'h2100);
        ow(fop(6'h00, 1'b1, 7'h28), 8'h5a, fs);
        put(14'h2a00);
        put(fop(6'h00, 1'b1, 7'h24));
        pm.rom[13'h0900] = lop(6'h34, 8'h5a);
        pm.rom[13'h0901] = 14'h0008;
        pm.rom[13'h0b00] = 14'h0009;
        wp = 13'h0a00;
        ow(fop(6'h00, 1'b1, 7'h29), 8'h5a, fs);
        put(14'h0064);
        ow(fop(6'h00, 1'b1, 7'h2a), 8'h5a, fs);
        put(14'h0063);
        put(14'h2300);
        ow(fop(6'h00, 1'b1, 7'h01), 8'h5a, fs);
        ow(fop(6'h08, 1'b1, 7'h05), p, {fs[2:1], 1'b0});
        put(14'h2a07);
        repeat (5) @(posedge mclk);
        #1;
        rst = 1'b0;
        for (int i = 0; i < 3000 && !(prog_addr === 13'h0a07 && notes.size() == 0); i++) begin
            @(posedge mclk);
        end
        @(negedge mclk);
        hold_ce = 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        `RID_CHECK(notes.size(), 0)
        `RID_CHECK(prog_addr, 13'h0a07)
        `RID_CHECK(acc, 8'h5a)
        `RID_CHECK(flags.watchdog_expiry_flag, 1'b1)
        `RID_CHECK(flags.sleep_entered_flag, 1'b0)
        `RID_CHECK(global_irq_enable, 1'b1)
        `RID_CHECK(n_wdt, 2)
        `RID_CHECK(n_sleep, 1)
        `RID_CHECK(n_presc, 1)
        gie_clear = 1'b1;
        @(posedge mclk);
        #1;
        gie_clear = 1'b0;
        `RID_CHECK(global_irq_enable, 1'b0)
        give_verdict();
    end
endmodule
`default_nettype wire
